// >>> hdl/ext_data_bus_gpio_pin_mux.v
// Pin multiplexer for data bits 7..15 shared with port F pins 0..8, AXI4-Lite regs.
// Assumes the memory interface drives bus_* from aclk; pads reach a top-level tristate cell.
`timescale 1ns/1ps
`include "pin_mux_consts.vh"
// Functional notes
// [RQ1] In bus mode data pins 7..15 carry external memory data.
// [RQ2] With the hold bit clear, pins 7..14 float while bus is idle.
// [RQ3] Software should set the hold bit to one to avoid floating pins.
// [RQ4] Each port F pin individually selectable as input or output in GPIO mode.
// [RQ5] Reset selects data bus function on all nine shared pins.
// [RQ6] Pins 0..7: clearing pull-up register bit disables the pull-up.
// [RQ7] Pin 8: setting pull-up register bit 8 disables the pull-up.
// [RQ8] During reset drivers are off and pull-ups are on.
// [RQ9] Peripheral-enable register lets software change bus/GPIO selection.
module ext_data_bus_gpio_pin_mux
#(
  parameter NPINS = `NPINS
)
(
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire bus_active,
  input wire bus_oe,
  input wire [NPINS-1:0] bus_wdata,
  output reg [NPINS-1:0] bus_rdata,
  input wire [NPINS-1:0] pad_in,
  output wire [NPINS-1:0] pad_out,
  output wire [NPINS-1:0] pad_oe,
  output wire [NPINS-1:0] pad_pullup_en
);

////////////////////////////////////////////////////////////////////////////
  reg [31:0] bus_ctrl_q;
  reg [NPINS-1:0] periph_en_q;
  reg [NPINS-1:0] dir_q;
  reg [NPINS-1:0] dout_q;
  reg [NPINS-1:0] pullup_q;
  reg [NPINS-1:0] sync1_q;
  reg [NPINS-1:0] sync2_q;
  reg [7:0] awaddr_q;
  reg aw_have_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_have_q;
  wire do_write;
  wire do_read;
  wire [31:0] strb_mask;
  wire [31:0] rd_mux;
  reg [31:0] rd_word;
  reg rd_hit;
  reg wr_hit;
  wire bus_float;

  assign strb_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  // Address and data taken independently, one write outstanding
  assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_have_q & ~s_axi_bvalid;
  assign do_write = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_read = s_axi_arvalid & ~s_axi_rvalid;

////////////////////////////////////////////////////////////////////////////
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      else if (do_write)
        aw_have_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      else if (do_write)
        w_have_q <= 1'b0;
    end
  end

  always @*
  begin
    wr_hit = 1'b1;
    if (awaddr_q == `OFS_BUS_CTRL)
      wr_hit = 1'b1;
    else if (awaddr_q == `OFS_PERIPH_EN)
      wr_hit = 1'b1;
    else if (awaddr_q == `OFS_DIR)
      wr_hit = 1'b1;
    else if (awaddr_q == `OFS_DATA_OUT)
      wr_hit = 1'b1;
    else if (awaddr_q == `OFS_PULLUP)
      wr_hit = 1'b1;
    else
      wr_hit = 1'b0;
  end

  // Registers reset to bus mode, drivers inputs, pull-ups on
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bus_ctrl_q <= `RST_BUS_CTRL;
      periph_en_q <= `RST_PERIPH_EN; // [RQ5]
      dir_q <= `RST_DIR;
      dout_q <= `RST_DATA_OUT;
      pullup_q <= `RST_PULLUP; // [RQ8]
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else
    begin
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        if (awaddr_q == `OFS_BUS_CTRL)
          bus_ctrl_q <= (bus_ctrl_q & ~strb_mask) | (wdata_q & strb_mask); // [RQ3]
        else if (awaddr_q == `OFS_PERIPH_EN)
          periph_en_q <= (periph_en_q & ~strb_mask[NPINS-1:0]) | (wdata_q[NPINS-1:0] & strb_mask[NPINS-1:0]); // [RQ9]
        else if (awaddr_q == `OFS_DIR)
          dir_q <= (dir_q & ~strb_mask[NPINS-1:0]) | (wdata_q[NPINS-1:0] & strb_mask[NPINS-1:0]); // [RQ4]
        else if (awaddr_q == `OFS_DATA_OUT)
          dout_q <= (dout_q & ~strb_mask[NPINS-1:0]) | (wdata_q[NPINS-1:0] & strb_mask[NPINS-1:0]);
        else if (awaddr_q == `OFS_PULLUP)
          pullup_q <= (pullup_q & ~strb_mask[NPINS-1:0]) | (wdata_q[NPINS-1:0] & strb_mask[NPINS-1:0]);
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

////////////////////////////////////////////////////////////////////////////
  always @*
  begin
    rd_hit = 1'b1;
    rd_word = 32'h0000_0000;
    if (s_axi_araddr == `OFS_BUS_CTRL)
      rd_word = bus_ctrl_q;
    else if (s_axi_araddr == `OFS_PERIPH_EN)
      rd_word[NPINS-1:0] = periph_en_q;
    else if (s_axi_araddr == `OFS_DIR)
      rd_word[NPINS-1:0] = dir_q;
    else if (s_axi_araddr == `OFS_DATA_OUT)
      rd_word[NPINS-1:0] = dout_q;
    else if (s_axi_araddr == `OFS_PULLUP)
      rd_word[NPINS-1:0] = pullup_q;
    else if (s_axi_araddr == `OFS_PIN_IN)
      rd_word[NPINS-1:0] = sync2_q;
    else if (s_axi_araddr == `OFS_STATUS)
      rd_word[1:0] = {bus_float, bus_active};
    else
      rd_hit = 1'b0;
  end
  assign rd_mux = rd_word;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (do_read)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

////////////////////////////////////////////////////////////////////////////
  // Pads are asynchronous to aclk, so two stages before use
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_q <= {NPINS{1'b0}};
      sync2_q <= {NPINS{1'b0}};
      bus_rdata <= {NPINS{1'b0}};
    end
    else
    begin
      sync1_q <= pad_in;
      sync2_q <= sync1_q;
      bus_rdata <= sync2_q; // [RQ1]
    end
  end

  // Bit 8 has no float control: only 7..14 float when hold bit is clear
  assign bus_float = ~bus_ctrl_q[`BUS_DRIVE_HOLD_POS] & ~bus_active; // [RQ2]

  genvar i;
  generate
    for (i = 0; i < NPINS; i = i + 1)
    begin : g_pin
      pin_slice u_pin
      (
        .in_reset(~aresetn),
        .bus_sel(periph_en_q[i]),
        .bus_oe(bus_oe),
        .bus_out(bus_wdata[i]),
        .bus_float((i == `PIN8_IDX) ? 1'b0 : bus_float),
        .gpio_dir(dir_q[i]),
        .gpio_out(dout_q[i]),
        .pu_bit(pullup_q[i]),
        .pu_clear_disables((i == `PIN8_IDX) ? 1'b0 : 1'b1),
        .pad_out(pad_out[i]),
        .pad_oe(pad_oe[i]),
        .pad_pullup_en(pad_pullup_en[i])
      );
    end
  endgenerate

endmodule

// >>> hdl/pin_mux_consts.vh
// Constants for the external data bus / port F pin multiplexer.
// Assumes the includer works in byte addresses on a 32-bit AXI4-Lite bus.
`ifndef PIN_MUX_CONSTS_VH
`define PIN_MUX_CONSTS_VH

`define OFS_BUS_CTRL 8'h00
`define OFS_PERIPH_EN 8'h04
`define OFS_DIR 8'h08
`define OFS_DATA_OUT 8'h0C
`define OFS_PULLUP 8'h10
`define OFS_PIN_IN 8'h14
`define OFS_STATUS 8'h18

`define BUS_DRIVE_HOLD_POS 0
`define NPINS 9
`define RST_BUS_CTRL 32'h0000_0000
`define RST_PERIPH_EN 9'h1FF
`define RST_DIR 9'h000
`define RST_DATA_OUT 9'h000
`define RST_PULLUP 9'h0FF
`define PIN8_IDX 8

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> hdl/pin_slice.v
// One shared pin: chooses between bus and GPIO ownership, drive and pull-up.
// Assumes all inputs come from aclk-domain logic; pad input is synchronised elsewhere.
`timescale 1ns/1ps
module pin_slice
(
  input wire in_reset,
  input wire bus_sel,
  input wire bus_oe,
  input wire bus_out,
  input wire bus_float,
  input wire gpio_dir,
  input wire gpio_out,
  input wire pu_bit,
  input wire pu_clear_disables,
  output wire pad_out,
  output wire pad_oe,
  output wire pad_pullup_en
);
  // Reset forces driver off and pull-up on
  assign pad_oe = in_reset ? 1'b0 : bus_sel ? (bus_oe & ~bus_float) : gpio_dir; // [RQ8] [RQ2] [RQ4]
  assign pad_out = bus_sel ? bus_out : gpio_out; // [RQ1]
  // Pins 0..7 use clear-to-disable, pin 8 set-to-disable
  assign pad_pullup_en = in_reset ? 1'b1 : pu_clear_disables ? pu_bit : ~pu_bit; // [RQ8] [RQ6] [RQ7]
endmodule

// >>> verification/ext_mem_model.sv
// External static memory on the nine shared data pins.
// Assumes rd and wr come from the memory interface strobes.
`timescale 1ns/1ps
module ext_mem_model
(
  input wire aclk,
  input wire rd,
  input wire wr,
  input wire [8:0] pad_out,
  input wire [8:0] pad_oe,
  input wire [8:0] pad_pullup_en,
  output logic [8:0] pad_in
);
  logic [8:0] mem_q = 9'h000;
  logic [8:0] last_q = 9'h000;
  always @(posedge aclk)
  begin
    if (wr)
      mem_q <= pad_out;
    last_q <= pad_in;
  end
  // A floating pin without pull-up toggles, so a stale level never looks right
  always_comb
    for (int i = 0; i < 9; i++)
      pad_in[i] = pad_oe[i] ? pad_out[i] : rd ? mem_q[i] : pad_pullup_en[i] ? 1'b1 : ~last_q[i];
endmodule

// >>> verification/pin_mux_checker_assertions.sv
// Port checker for the data bus / port F pin mux.
// Bound into every mux instance by name.
`timescale 1ns/1ps
module pin_mux_checker
#(parameter NPINS = 9)
(
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire bus_active,
  input wire bus_oe,
  input wire [NPINS-1:0] bus_wdata,
  input wire [NPINS-1:0] pad_out,
  input wire [NPINS-1:0] pad_oe,
  input wire [NPINS-1:0] pad_pullup_en
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Reset itself is the cause here, so this one is never disabled
  rst_pins_a: assert property (disable iff (1'b0) !aresetn |-> !pad_oe && &pad_pullup_en)
    else $error("pins live in reset");
  rst_mode_a: assert property ($rose(aresetn) |-> pad_oe == {bus_oe, {8{bus_oe && bus_active}}})
    else $error("bad mode after reset");
  bus_data_a: assert property ($rose(aresetn) |-> (pad_out & pad_oe) == (bus_wdata & pad_oe))
    else $error("bus data missing");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken early");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken early");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer stuck");
  wr_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer stuck");
  cover property (s_axi_bvalid);
  cover property (s_axi_rvalid);
  cover property (pad_oe == 9'h100);
endmodule
bind ext_data_bus_gpio_pin_mux pin_mux_checker #(.NPINS(NPINS)) checker_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .bus_active(bus_active), .bus_oe(bus_oe), .bus_wdata(bus_wdata),
  .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_en(pad_pullup_en));

// >>> verification/tb.sv
// Self-checking bench for the pin mux with a memory model.
// Assumes hdl/ is on the include path.
`timescale 1ns/1ps
`include "pin_mux_consts.vh"
module tb;
  logic aclk = 0, aresetn = 0, bus_active = 0, bus_oe = 0, s_axi_bready = 1, s_axi_rready = 1;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, seed = 32'h63, r, d, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [8:0] bus_wdata = 9'h000, bus_rdata, pad_in, pad_out, pad_oe, pad_pullup_en;
  logic [8:0] rv [5] = '{9'h000, 9'h1FF, 9'h000, 9'h000, 9'h0FF};
  logic [33:0] exp_q [$];
  int failures = 0, total_checks = 0;
  ext_data_bus_gpio_pin_mux dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .bus_active(bus_active), .bus_oe(bus_oe), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_en(pad_pullup_en));
  ext_mem_model mem (.aclk(aclk), .rd(bus_active && !bus_oe), .wr(bus_active && bus_oe),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_en(pad_pullup_en), .pad_in(pad_in));
  always #20 aclk = ~aclk;
  ////////////////////////////////
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input logic [33:0] s, input logic [33:0] e);
    total_checks++;
    if (s !== e)
    begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task print_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Handshakes sampled at the falling edge are stable up to the next rising edge
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] v, input logic [33:0] e);
    logic ta, tw, tr, done;
    exp_q.push_back(e);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_arvalid <= !w;
    done = 0;
    while (!done)
    begin
      @(negedge aclk);
      ta = s_axi_awready && s_axi_awvalid;
      tw = s_axi_wready && s_axi_wvalid;
      tr = s_axi_arready && s_axi_arvalid;
      done = s_axi_bvalid || s_axi_rvalid;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      if (tr) s_axi_arvalid <= 0;
    end
  endtask
  always @(posedge aclk)
    if (s_axi_bvalid || s_axi_rvalid)
      chk(s_axi_bvalid ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
  initial
  begin
    #200000;
    failures++;
    print_verdict();
  end
  ////////////////////////////////
  initial
  begin
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk({pad_oe, pad_pullup_en}, 18'h001FF);
    @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    for (int i = 0; i < 5; i++)
      xfer(0, 8'(i * 4), 32'h0, {25'h0, rv[i]});
    xfer(0, 8'h1C, 32'h0, {`RESP_SLVERR, 32'h0});
    xfer(0, `OFS_STATUS, 32'h0, 34'h2);
    $display("register test done");
    r = xs();
    bus_wdata <= r[8:0];
    bus_oe <= 1;
    @(negedge aclk);
    chk(pad_oe, 9'h100);
    @(posedge aclk);
    bus_active <= 1;
    @(negedge aclk);
    chk({pad_oe, pad_out}, {9'h1FF, r[8:0]});
    @(posedge aclk);
    bus_oe <= 0;
    repeat (5) @(posedge aclk);
    @(negedge aclk);
    chk(bus_rdata, r[8:0]);
    @(posedge aclk);
    bus_active <= 0;
    bus_oe <= 1;
    xfer(1, `OFS_BUS_CTRL, 32'h1, 34'h0);
    @(negedge aclk);
    chk(pad_oe, 9'h1FF);
    $display("bus test done");
    d = xs();
    r = xs();
    @(posedge aclk);
    xfer(1, `OFS_PERIPH_EN, 32'h0, 34'h0);
    xfer(1, `OFS_DIR, d, 34'h0);
    xfer(1, `OFS_DATA_OUT, r, 34'h0);
    @(negedge aclk);
    chk({pad_oe, pad_out & d[8:0]}, {d[8:0], r[8:0] & d[8:0]});
    // Input pins see the pull-up, output pins read back their own drive
    @(posedge aclk);
    xfer(0, `OFS_PIN_IN, 32'h0, {25'h0, (r[8:0] & d[8:0]) | ~d[8:0]});
    $display("gpio test done");
    for (int i = 0; i < 2; i++)
    begin
      @(posedge aclk);
      r = (xs() & 32'hFFFF_FEFF) | (32'(i) << 8);
      xfer(1, `OFS_PULLUP, r, 34'h0);
      @(negedge aclk);
      chk(pad_pullup_en, {~r[8], r[7:0]});
    end
    $display("pullup test done");
    @(posedge aclk);
    aresetn <= 0;
    @(negedge aclk);
    chk({pad_oe, pad_pullup_en}, 18'h001FF);
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(negedge aclk);
    chk(pad_oe, 9'h100);
    $display("reset test done");
    print_verdict();
  end
endmodule
